/* File: pkg/i2m_defines.svh */
// Purpose: constants of the two-wire memory slave front end
// Assumes: included by bare name in the package and the bench; the slave uses the constants without an include
// Notes:   definitions only
`ifndef I2M_DEFINES_SVH
`define I2M_DEFINES_SVH

// memory address width, bits 16..0
`define I2M_ADDR_W    17
// fixed upper nibble of the memory slave address, 1010b
`define I2M_MEM_ID    4'ha
// bit counter values: data bits done, acknowledge slot
`define I2M_BYTE_BITS 4'h8
`define I2M_ACK_SLOT  4'h9
// reset value of the memory address pointer
`define I2M_ADDR_RST  17'h00000

`endif

/* File: pkg/i2m_pkg.sv */
// Purpose: types of the two-wire memory slave front end
// Assumes: i2m_defines.svh holds the numbers
// Notes:   every state of the block lives in the two structs below
`include "i2m_defines.svh"

package i2m_pkg;

	// protocol state of the link side
	typedef enum logic [2:0] {
		st_idle,
		st_slave,
		st_addr_hi,
		st_addr_lo,
		st_wdata,
		st_rdata,
		st_ignore
	} i2m_state_type;

	// one memory access, as carried across the domains and to the user
	typedef struct packed {
		logic                    we;
		logic [`I2M_ADDR_W-1:0] addr;
		logic [7:0]              wdata;
	} i2m_req_type;

	// all state clocked by the link clock
	typedef struct packed {
		logic                    scl_m, scl_s, scl_p;
		logic                    sda_m, sda_s, sda_p;
		logic [1:0]              sel_m, sel_s;
		logic                    wp_m, wp_s;
		logic                    ce_m, ce_s;
		logic                    rst_m, rst_s;
		logic                    ack_m, ack_s, ack_p;
		i2m_state_type           st;
		logic [3:0]              cnt;
		logic [7:0]              shreg;
		logic [7:0]              tx;
		logic [`I2M_ADDR_W-1:0] addr;
		logic                    rd;
		logic                    nak;
		logic                    mack;
		logic                    oe;
		logic                    sda_out;
		logic                    req_tog;
		i2m_req_type             req;
	} i2m_link_type;

	// all state clocked by the system clock
	typedef struct packed {
		logic        req_m, req_s, req_p;
		logic        mem_req;
		logic        pend;
		i2m_req_type mem;
		logic [7:0]  rdata;
		logic        ack_tog;
	} i2m_sys_type;

endpackage

/* File: hdl/i2m_slave.sv */
// Purpose: two-wire bus slave front end of a byte-wide memory
// Assumes: link_clk_i oversamples the bus pins; memory answers one cycle after a request
// Notes:   protocol runs on link_clk_i, memory port on clock_i, joined by toggle handshakes
`timescale 1ns/10ps

// Functional notes
// R1: only seven-bit slave addressing; first byte after start is address plus direction.
// R2: direction bit one means read, zero means write.
// R3: acknowledge the slave byte when the address matches our own.
// R4: when not addressed, ignore the data line until stop or repeated start.
// R5: the receiver acknowledges by pulling data low in the ninth clock.
// R6: master sends address bytes then data bytes, ending with stop or restart.
// R7: pointer increments on the ninth falling edge, latched before the acknowledge.
// R8: pointer wraps from the last location to zero and the burst continues.
// R9: acknowledge every write byte except corrupted or protected ones.
// R10: a read without address starts at the current pointer.
// R11: random read: master writes the address then restarts before any data.
// R12: after an address-only write, the next read starts at that address.
// R13: master acknowledges each read byte it wants followed by another.
// R14: on master not-acknowledge, release the data line and wait for stop or restart.
// R15: data changes only while clock is low, except start and stop.
// R16: start is data falling while clock is high; it opens every transaction.
// R17: stop is data rising while clock is high; it ends the transaction.
// R18: repeated start abandons the transfer and awaits a new slave byte.
// R19: bytes are eight bits, most significant first, then an acknowledge slot.
// R20: transmitter releases data after a byte; no acknowledge aborts the operation.
// R21: not-acknowledge write data aimed at protected locations.
// R22: slave works up to the highest supported bus clock rate.
// R23: memory slave address is 1010, two select pins, then address bit sixteen.
// R24: address is seventeen bits; two bytes carry bits 15..0, top bit in slave byte.
// R25: asserted write protect blocks every write to the array.
// R26: address bytes travel high byte first, then low byte.
module i2m_slave (
	// system side
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// link side
	input  wire logic              link_clk_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	// straps and protection pins
	input  wire logic              slave_select_pin_high_i,
	input  wire logic              slave_select_pin_low_i,
	input  wire logic              wp_i,
	// memory port
	output logic                   mem_req_o,
	output i2m_pkg::i2m_req_type   mem_o,
	input  wire logic [7:0]        mem_rdata_i
);

	i2m_pkg::i2m_link_type lk_r;
	i2m_pkg::i2m_link_type lk_nxt;
	i2m_pkg::i2m_sys_type  sy_r;
	i2m_pkg::i2m_sys_type  sy_nxt;

	logic start_w;
	logic stop_w;
	logic rise_w;
	logic fall_w;
	logic match_w;
	logic ack_evt_w;
	logic rx_st_w;
	logic req_evt_w;

	////////////////////////////////////////////////////////////////////////////////
	// bus events from the synchronised pins
	// sampling at the link clock keeps several samples per bus bit [R22]
	assign start_w   = lk_r.scl_s & lk_r.scl_p & lk_r.sda_p & ~lk_r.sda_s; // [R16]
	assign stop_w    = lk_r.scl_s & lk_r.scl_p & ~lk_r.sda_p & lk_r.sda_s; // [R17]
	assign rise_w    = lk_r.scl_s & ~lk_r.scl_p;
	assign fall_w    = ~lk_r.scl_s & lk_r.scl_p;
	// fixed nibble plus the two select straps [R1] [R23]
	assign match_w   = (lk_r.shreg[7:4] == `I2M_MEM_ID) &&
	                   (lk_r.shreg[3:2] == lk_r.sel_s);
	assign ack_evt_w = lk_r.ack_s ^ lk_r.ack_p;
	assign rx_st_w   = (lk_r.st == i2m_pkg::st_slave) || (lk_r.st == i2m_pkg::st_addr_hi) ||
	                   (lk_r.st == i2m_pkg::st_addr_lo) || (lk_r.st == i2m_pkg::st_wdata);

	////////////////////////////////////////////////////////////////////////////////
	// link side next state
	always_comb begin
		lk_nxt = lk_r;
		// two-flop synchronisers, always running so reset and enable reach us
		lk_nxt.scl_m = scl_i;
		lk_nxt.scl_s = lk_r.scl_m;
		lk_nxt.scl_p = lk_r.scl_s;
		lk_nxt.sda_m = sda_i;
		lk_nxt.sda_s = lk_r.sda_m;
		lk_nxt.sda_p = lk_r.sda_s;
		lk_nxt.sel_m = {slave_select_pin_high_i, slave_select_pin_low_i};
		lk_nxt.sel_s = lk_r.sel_m;
		lk_nxt.wp_m  = wp_i;
		lk_nxt.wp_s  = lk_r.wp_m;
		lk_nxt.ce_m  = ce_i;
		lk_nxt.ce_s  = lk_r.ce_m;
		lk_nxt.rst_m = rst_i;
		lk_nxt.rst_s = lk_r.rst_m;
		lk_nxt.ack_m = sy_r.ack_tog;
		lk_nxt.ack_s = lk_r.ack_m;
		lk_nxt.ack_p = lk_r.ack_s;
		if (lk_r.rst_s) begin
			lk_nxt.st      = i2m_pkg::st_idle;
			lk_nxt.cnt     = 4'h0;
			lk_nxt.shreg   = 8'h00;
			lk_nxt.tx      = 8'h00;
			lk_nxt.addr    = `I2M_ADDR_RST;
			lk_nxt.rd      = 1'b0;
			lk_nxt.nak     = 1'b0;
			lk_nxt.mack    = 1'b0;
			lk_nxt.oe      = 1'b0;
			lk_nxt.sda_out = 1'b0;
			lk_nxt.req_tog = 1'b0;
			lk_nxt.req     = '0;
			lk_nxt.ack_p   = lk_r.ack_s;
		end else if (!lk_r.ce_s) begin
			// frozen: keep the handshake edge pending until enabled again
			lk_nxt.ack_p = lk_r.ack_p;
		end else begin
			// read data lands whenever the memory answers; edge consumed once
			lk_nxt.ack_p = lk_r.ack_s;
			if (ack_evt_w) begin
				lk_nxt.tx = sy_r.rdata;
			end
			if (start_w) begin
				// start and repeated start alike wait for a slave byte [R18]
				lk_nxt.st  = i2m_pkg::st_slave;
				lk_nxt.cnt = 4'h0;
				lk_nxt.oe  = 1'b0;
				lk_nxt.nak = 1'b0;
			end else if (stop_w) begin
				lk_nxt.st  = i2m_pkg::st_idle; // [R17]
				lk_nxt.cnt = 4'h0;
				lk_nxt.oe  = 1'b0;
			end else if (rx_st_w) begin
				if (rise_w && lk_r.cnt < `I2M_BYTE_BITS) begin
					// msb first into the shifter [R19] [R15]
					lk_nxt.shreg = {lk_r.shreg[6:0], lk_r.sda_s};
					lk_nxt.cnt   = lk_r.cnt + 4'h1;
				end else if (fall_w && lk_r.cnt == `I2M_BYTE_BITS) begin
					// byte complete: decide the acknowledge before the ninth clock
					lk_nxt.cnt = `I2M_ACK_SLOT;
					unique case (lk_r.st)
						i2m_pkg::st_slave: begin
							if (match_w) begin
								lk_nxt.oe = 1'b1; // [R3] [R5]
								lk_nxt.rd = lk_r.shreg[0]; // [R2]
								if (lk_r.shreg[0]) begin
									// fetch the current pointer for the first byte [R10] [R12]
									lk_nxt.req.we   = 1'b0;
									lk_nxt.req.addr = lk_r.addr;
									lk_nxt.req_tog  = ~lk_r.req_tog;
								end else begin
									lk_nxt.addr[`I2M_ADDR_W-1] = lk_r.shreg[1]; // [R24]
								end
							end else begin
								lk_nxt.st = i2m_pkg::st_ignore; // [R4]
							end
						end
						i2m_pkg::st_addr_hi: begin
							lk_nxt.addr[15:8] = lk_r.shreg; // [R26] [R7]
							lk_nxt.oe         = 1'b1;
						end
						i2m_pkg::st_addr_lo: begin
							lk_nxt.addr[7:0] = lk_r.shreg; // [R26] [R7]
							lk_nxt.oe        = 1'b1;
						end
						i2m_pkg::st_wdata: begin
							if (lk_r.wp_s) begin
								// refuse: no write, line left high [R21] [R25]
								lk_nxt.nak = 1'b1;
							end else begin
								lk_nxt.oe        = 1'b1; // [R9]
								lk_nxt.req.we    = 1'b1;
								lk_nxt.req.addr  = lk_r.addr;
								lk_nxt.req.wdata = lk_r.shreg;
								lk_nxt.req_tog   = ~lk_r.req_tog;
							end
						end
						default: ;
					endcase
				end else if (fall_w && lk_r.cnt == `I2M_ACK_SLOT) begin
					// end of the ninth clock: release and move on
					lk_nxt.oe  = 1'b0;
					lk_nxt.cnt = 4'h0;
					unique case (lk_r.st)
						i2m_pkg::st_slave: begin
							// master restarts after the address bytes for a random read [R11]
							lk_nxt.st = lk_r.rd ? i2m_pkg::st_rdata : i2m_pkg::st_addr_hi;
							lk_nxt.oe = lk_r.rd & ~lk_r.tx[7];
						end
						i2m_pkg::st_addr_hi: lk_nxt.st = i2m_pkg::st_addr_lo;
						i2m_pkg::st_addr_lo: lk_nxt.st = i2m_pkg::st_wdata; // [R6]
						i2m_pkg::st_wdata: begin
							if (lk_r.nak) begin
								lk_nxt.st = i2m_pkg::st_ignore; // [R20]
							end else begin
								// natural 17-bit wrap to zero [R7] [R8]
								lk_nxt.addr = lk_r.addr + 17'h1;
							end
						end
						default: ;
					endcase
				end
			end else if (lk_r.st == i2m_pkg::st_rdata) begin
				if (rise_w && lk_r.cnt < `I2M_BYTE_BITS) begin
					lk_nxt.cnt = lk_r.cnt + 4'h1;
				end else if (rise_w && lk_r.cnt == `I2M_BYTE_BITS) begin
					// low in the ninth clock means more bytes wanted [R13]
					lk_nxt.mack = ~lk_r.sda_s;
					lk_nxt.cnt  = `I2M_ACK_SLOT;
				end else if (fall_w && lk_r.cnt != 4'h0 && lk_r.cnt < `I2M_BYTE_BITS) begin
					// next bit, msb first, driven only while clock is low [R19] [R15]
					lk_nxt.oe = ~lk_r.tx[3'(4'h7 - lk_r.cnt)];
				end else if (fall_w && lk_r.cnt == `I2M_BYTE_BITS) begin
					// let go for the master's answer and prefetch the next byte [R20]
					lk_nxt.oe       = 1'b0;
					lk_nxt.req.we   = 1'b0;
					lk_nxt.req.addr = lk_r.addr + 17'h1;
					lk_nxt.req_tog  = ~lk_r.req_tog;
				end else if (fall_w && lk_r.cnt == `I2M_ACK_SLOT) begin
					lk_nxt.addr = lk_r.addr + 17'h1; // [R7] [R8]
					lk_nxt.cnt  = 4'h0;
					if (lk_r.mack) begin
						lk_nxt.oe = ~lk_r.tx[7];
					end else begin
						lk_nxt.oe = 1'b0; // [R14]
						lk_nxt.st = i2m_pkg::st_ignore;
					end
				end
			end
		end
	end

	// link side register
	always_ff @(posedge link_clk_i) begin
		lk_r <= lk_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// system side: turn each request toggle into one memory cycle
	// request fields are stable for a whole bus byte, so they cross unsynchronised
	assign req_evt_w = sy_r.req_s ^ sy_r.req_p;

	always_comb begin
		sy_nxt       = sy_r;
		sy_nxt.req_m = lk_r.req_tog;
		sy_nxt.req_s = sy_r.req_m;
		if (rst_i) begin
			sy_nxt.req_p   = 1'b0;
			sy_nxt.mem_req = 1'b0;
			sy_nxt.pend    = 1'b0;
			sy_nxt.mem     = '0;
			sy_nxt.rdata   = 8'h00;
			sy_nxt.ack_tog = 1'b0;
		end else if (ce_i) begin
			sy_nxt.req_p   = sy_r.req_s;
			sy_nxt.mem_req = req_evt_w;
			sy_nxt.pend    = sy_r.mem_req;
			if (req_evt_w) begin
				sy_nxt.mem = lk_r.req;
			end
			// answer sampled one cycle after the strobe, then handed back
			if (sy_r.pend) begin
				sy_nxt.rdata   = sy_r.mem.we ? sy_r.rdata : mem_rdata_i;
				sy_nxt.ack_tog = ~sy_r.ack_tog;
			end
		end
	end

	// system side register
	always_ff @(posedge clock_i) begin
		sy_r <= sy_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, each straight from a flip-flop
	assign sda_o     = lk_r.sda_out;
	assign sda_oe_o  = lk_r.oe;
	assign mem_req_o = sy_r.mem_req;
	assign mem_o     = sy_r.mem;

	////////////////////////////////////////////////////////////////////////////////
	// checks on the link side
	a_slave_ack_match: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R3]
		(lk_r.ce_s && !start_w && !stop_w && lk_r.st == i2m_pkg::st_slave && fall_w &&
		 lk_r.cnt == `I2M_BYTE_BITS && match_w) |=> sda_oe_o [*2])
		else $error("matching slave byte not acknowledged");

	a_ignore_quiet: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R4]
		(lk_r.st == i2m_pkg::st_ignore) |-> !sda_oe_o)
		else $error("data line driven while not addressed");

	a_wp_refuse: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R25]
		(lk_r.ce_s && !start_w && !stop_w && lk_r.st == i2m_pkg::st_wdata && fall_w &&
		 lk_r.cnt == `I2M_BYTE_BITS && lk_r.wp_s) |=> !sda_oe_o && $stable(lk_r.req_tog))
		else $error("protected write acknowledged or issued");

	a_restart_slave: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R18]
		(lk_r.ce_s && start_w) |=> lk_r.st == i2m_pkg::st_slave && lk_r.cnt == 4'h0 && !sda_oe_o)
		else $error("start did not reopen the slave byte");

	a_stop_idle: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R17]
		(lk_r.ce_s && stop_w) |=> lk_r.st == i2m_pkg::st_idle && !sda_oe_o)
		else $error("stop did not free the slave");

	a_addr_incr: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R7]
		(lk_r.ce_s && !start_w && !stop_w && lk_r.st == i2m_pkg::st_wdata && fall_w &&
		 lk_r.cnt == `I2M_ACK_SLOT && !lk_r.nak) |=> lk_r.addr == $past(lk_r.addr) + 17'h1)
		else $error("pointer not advanced after write byte");

	a_oe_rise_low: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R15]
		$rose(sda_oe_o) |-> !lk_r.scl_p)
		else $error("data line pulled low while clock high");

	a_read_current: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R10]
		(lk_r.ce_s && !start_w && !stop_w && lk_r.st == i2m_pkg::st_slave && fall_w &&
		 lk_r.cnt == `I2M_BYTE_BITS && match_w && lk_r.shreg[0])
		|=> !lk_r.req.we && lk_r.req.addr == $past(lk_r.addr) && lk_r.req_tog != $past(lk_r.req_tog))
		else $error("read did not start at current pointer");

	a_master_nack: assert property (@(posedge link_clk_i) disable iff (lk_r.rst_s) // [R14]
		(lk_r.ce_s && !start_w && !stop_w && lk_r.st == i2m_pkg::st_rdata && fall_w &&
		 lk_r.cnt == `I2M_ACK_SLOT && !lk_r.mack) |=> !sda_oe_o && lk_r.st == i2m_pkg::st_ignore)
		else $error("transmitter kept the line after master refusal");

	// checks on the system side
	a_mem_strobe: assert property (@(posedge clock_i) disable iff (rst_i) // [R9]
		(ce_i && req_evt_w) |=> mem_req_o ##1 !mem_req_o)
		else $error("memory strobe not a single pulse");

	c_read_byte: cover property (@(posedge link_clk_i) disable iff (lk_r.rst_s)
		lk_r.st == i2m_pkg::st_rdata && fall_w && lk_r.cnt == `I2M_ACK_SLOT && lk_r.mack);
	c_write_byte: cover property (@(posedge clock_i) disable iff (rst_i)
		mem_req_o && mem_o.we);
	c_wp_refused: cover property (@(posedge link_clk_i) disable iff (lk_r.rst_s)
		lk_r.st == i2m_pkg::st_wdata && lk_r.nak);
	c_repeat_start: cover property (@(posedge link_clk_i) disable iff (lk_r.rst_s)
		start_w && lk_r.st != i2m_pkg::st_idle);

endmodule

/* File: bench/i2m_master.sv */
// Purpose: behavioural two-wire bus master facing the memory slave
// Assumes: open-drain data wire resolved by the bench, pull-up when released
// Notes:   clock stands high between frames; 1 means released on sda_o
`timescale 1ns/10ps

module i2m_master (
	// bus pins
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic sda_i
);
	// quarter bit time; slave needs ~250 ns round trip per phase
	localparam realtime QTR = 300.0;

	// idle bus: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// start and repeated start: data falls while clock high
	task automatic start();
		sda_o = 1'b1;
		#QTR;
		scl_o = 1'b1;
		#QTR;
		sda_o = 1'b0;
		#QTR;
		scl_o = 1'b0;
		#QTR;
	endtask

	// stop: data rises while clock high, clock then stands still
	task automatic stop();
		sda_o = 1'b0;
		#QTR;
		scl_o = 1'b1;
		#QTR;
		sda_o = 1'b1;
		#QTR;
	endtask

	// one clock pulse, data set only while the clock is low
	task automatic clk_bit(input logic b, output logic s);
		sda_o = b;
		#QTR;
		scl_o = 1'b1;
		#QTR;
		s = sda_i;
		#QTR;
		scl_o = 1'b0;
		#QTR;
	endtask

	////////////////////////////////////////////////////////////////////////
	// send a byte, msb first, release for the ack slot
	task automatic wr_byte(input logic [7:0] d, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		acked = ~s;
	endtask

	// receive a byte; last one answered with not-acknowledge
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(last, s);
	endtask
endmodule

/* File: bench/tb_i2c_memory_slave_protocol.sv */
// Purpose: self-checking bench of the two-wire memory slave
// Assumes: memory model answers the cycle after a request
// Notes:   memory preloaded with address low byte xor 5a
`timescale 1ns/10ps
`include "i2m_defines.svh"

module tb_i2c_memory_slave_protocol;
	logic                 clock_i;
	logic                 rst_i;
	logic                 link_clk;
	logic                 wp;
	logic                 ce;
	logic [1:0]           sel;
	logic                 m_scl;
	logic                 m_sda;
	logic                 sda_d;
	logic                 sda_oe;
	logic                 mem_req;
	logic [7:0]           rdata;
	wire                  sda_w;
	i2m_pkg::i2m_req_type mem_q;
	logic [7:0]           mem [0:131071];
	int                   errors = 0;
	int                   checks = 0;
	int                   wr_cnt = 0;

	// open-drain wire: low if any party pulls, else pulled up
	assign sda_w = m_sda & (sda_oe ? sda_d : 1'b1);

	// system clock, 40 ns
	initial clock_i = 1'b0;
	always #20 clock_i = ~clock_i;

	// link clock, 15 ns, phase unrelated to the system clock
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	i2m_slave u_dut (
		.clock_i                 (clock_i),
		.rst_i                   (rst_i),
		.ce_i                    (ce),
		.link_clk_i              (link_clk),
		.scl_i                   (m_scl),
		.sda_i                   (sda_w),
		.sda_o                   (sda_d),
		.sda_oe_o                (sda_oe),
		.slave_select_pin_high_i (sel[1]),
		.slave_select_pin_low_i  (sel[0]),
		.wp_i                    (wp),
		.mem_req_o               (mem_req),
		.mem_o                   (mem_q),
		.mem_rdata_i             (rdata)
	);

	i2m_master u_mst (
		.scl_o (m_scl),
		.sda_o (m_sda),
		.sda_i (sda_w)
	);

	////////////////////////////////////////////////////////////////////////
	// memory model; read data stands from the cycle after the request
	initial begin
		rdata = 8'h00;
		for (int i = 0; i < 131072; i++) begin
			mem[i] = i[7:0] ^ 8'h5a;
		end
	end
	always @(posedge clock_i) begin
		if (mem_req) begin
			if (mem_q.we) begin
				mem[mem_q.addr] <= mem_q.wdata;
				wr_cnt <= wr_cnt + 1;
			end
			rdata <= mem[mem_q.addr];
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// slave byte: fixed nibble, select pair, top address bit, direction
	function automatic logic [7:0] sb(input logic [1:0] sel, input logic a16, input logic rd);
		return {`I2M_MEM_ID, sel, a16, rd};
	endfunction

	// write burst across the top of memory
	task automatic t_write();
		logic a;
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b1, 1'b0), a);
		chk(a, 1'b1);
		u_mst.wr_byte(8'hff, a);
		chk(a, 1'b1);
		u_mst.wr_byte(8'hfe, a);
		chk(a, 1'b1);
		for (int i = 0; i < 3; i++) begin
			u_mst.wr_byte(8'hc0 + i[7:0], a);
			chk(a, 1'b1);
		end
		u_mst.stop();
		chk(mem[17'h1fffe], 8'hc0);
		chk(mem[17'h1ffff], 8'hc1);
		chk(mem[17'h00000], 8'hc2);
		$display("test write burst done");
	endtask

	// read with no address: continues after last written location
	task automatic t_cur_read();
		logic       a;
		logic [7:0] d;
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b0, 1'b1), a);
		chk(a, 1'b1);
		u_mst.rd_byte(1'b1, d);
		chk(d, 8'h01 ^ 8'h5a);
		u_mst.stop();
		$display("test current read done");
	endtask

	// address-only write, repeated start, burst read over the wrap
	task automatic t_rand_read();
		logic       a;
		logic [7:0] d;
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b1, 1'b0), a);
		u_mst.wr_byte(8'hff, a);
		u_mst.wr_byte(8'hfe, a);
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b0, 1'b1), a);
		chk(a, 1'b1);
		for (int i = 0; i < 3; i++) begin
			u_mst.rd_byte(i == 2, d);
			chk(d, 8'hc0 + i[7:0]);
		end
		chk(sda_oe, 1'b0);
		u_mst.stop();
		$display("test random read done");
	endtask

	// other select pair: nothing acknowledged, nothing written
	task automatic t_no_match();
		logic a;
		int   n;
		n = wr_cnt;
		u_mst.start();
		u_mst.wr_byte(sb(2'b01, 1'b0, 1'b0), a);
		chk(a, 1'b0);
		u_mst.wr_byte(sb(2'b10, 1'b0, 1'b0), a);
		chk(a, 1'b0);
		u_mst.wr_byte(8'h00, a);
		chk(a, 1'b0);
		u_mst.stop();
		chk(wr_cnt, n);
		$display("test no match done");
	endtask

	// write protect: data refused, array untouched
	task automatic t_protect();
		logic a;
		int   n;
		n = wr_cnt;
		@(negedge clock_i);
		wp = 1'b1;
		repeat (4) @(negedge clock_i);
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b0, 1'b0), a);
		u_mst.wr_byte(8'h00, a);
		u_mst.wr_byte(8'h10, a);
		chk(a, 1'b1);
		u_mst.wr_byte(8'h77, a);
		chk(a, 1'b0);
		u_mst.stop();
		chk(wr_cnt, n);
		chk(mem[17'h00010], 8'h10 ^ 8'h5a);
		@(negedge clock_i);
		wp = 1'b0;
		$display("test write protect done");
	endtask

	// enable low freezes the slave; moved straps move its address
	task automatic t_pins();
		logic a;
		int   n;
		n = wr_cnt;
		@(negedge clock_i);
		ce = 1'b0;
		repeat (4) @(negedge clock_i);
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b0, 1'b0), a);
		chk(a, 1'b0);
		u_mst.wr_byte(8'h00, a);
		u_mst.stop();
		chk(wr_cnt, n);
		@(negedge clock_i);
		ce  = 1'b1;
		sel = 2'b01;
		repeat (4) @(negedge clock_i);
		u_mst.start();
		u_mst.wr_byte(sb(2'b10, 1'b0, 1'b0), a);
		chk(a, 1'b0);
		u_mst.start();
		u_mst.wr_byte(sb(2'b01, 1'b0, 1'b0), a);
		chk(a, 1'b1);
		u_mst.stop();
		@(negedge clock_i);
		sel = 2'b10;
		$display("test pins done");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog: tests take about 300 us of bus time
	initial begin
		#1_000_000;
		errors++;
		close_out();
	end

	// main sequence
	initial begin
		rst_i = 1'b1;
		wp = 1'b0;
		ce = 1'b1;
		sel = 2'b10;
		repeat (5) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (12) @(negedge clock_i);
		t_write();
		t_cur_read();
		t_rand_read();
		t_no_match();
		t_protect();
		t_pins();
		close_out();
	end
endmodule
